//--- rtl/ipm_pin_mux.v
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`include "ipm_consts.vh"
// Overview of operation
// - two-bit mode field picks port, waveform master or slave fifo pin use
// - after reset all shared pins are plain port bits
// - slave mode: first ready pin is read strobe, polarity from polarity bit 3
// - slave mode: second ready pin is write strobe, polarity from bit 2
// - control out 0 carries flag a, programmable level of selected fifo
// - control out 1 carries flag b, full of selected fifo
// - control out 2 carries flag c, empty of selected fifo
// - wake pin, programmable polarity, restarts oscillator and interrupts suspended core
// - wake pin held asserted blocks entry to suspend
// - port a bit 0 becomes active-low irq 0, edge or level
// - port a bit 1 becomes active-low irq 1, edge or level
// - slave mode: port a bit 2 is data output enable, polarity bit 4
// - port a bit 3 is second wake source when enabled, polarity from wake bit 4, shared with wake pin
// - second wake source wakes core on transition to its active level and blocks suspend
// - slave mode: port a bits 4 and 5 select the fifo
// - reset clears all config registers including mode and pin function choices, releases all port pin drivers and drives the control outputs high
// - waveform and slave modes: port b is low data byte
// - port d is high data byte only in fifo modes with word-wide endpoint
// - slave mode: packet commit input, polarity from bit 5
// - chip select on port a bit 7 gates all other slave strobes
module ipm_pin_mux (
  input wire ref_clk,
  input wire sys_rst,
  // register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // port a pins (oe low drives)
  input wire [7:0] port_a_in,
  output reg [7:0] port_a_out,
  output reg [7:0] port_a_oe_n,
  // port b pins
  input wire [7:0] port_b_in,
  output reg [7:0] port_b_out,
  output reg [7:0] port_b_oe_n,
  // port d pins
  input wire [7:0] port_d_in,
  output reg [7:0] port_d_out,
  output reg [7:0] port_d_oe_n,
  // ready pins and control pins
  input wire ready_input_0,
  input wire ready_input_1,
  output reg [2:0] ctl_pin_out,
  // core-side waveform engine
  input wire [2:0] waveform_ctrl_out,
  input wire [15:0] waveform_data_out,
  input wire waveform_data_drive,
  output reg [15:0] shared_data_in,
  output reg [1:0] ready_to_engine,
  // core-side slave fifo
  input wire [3:0] fifo_level_flag,
  input wire [3:0] fifo_full_flag,
  input wire [3:0] fifo_empty_flag,
  input wire [3:0] fifo_flag_d,
  input wire [15:0] fifo_read_data,
  output reg [1:0] fifo_select,
  output reg fifo_read_strobe,
  output reg fifo_write_strobe,
  output reg fifo_output_enable,
  output reg packet_commit_input,
  // port side data for the core
  input wire [7:0] port_b_reg_out,
  input wire [7:0] port_b_reg_oe,
  input wire [7:0] port_d_reg_out,
  input wire [7:0] port_d_reg_oe,
  output reg [7:0] port_a_pins,
  // wake and interrupts
  input wire wake_pin,
  input wire core_suspended,
  input wire suspend_request,
  input wire irq0_ack,
  input wire irq1_ack,
  output wire ext_irq0,
  output wire ext_irq1,
  output reg osc_restart,
  output reg wake_irq,
  output reg suspend_allowed
);
  reg [7:0] ifmode_reg;
  reg [7:0] polar_reg;
  reg [7:0] pacfg_reg;
  reg [7:0] wake_reg;
  reg [7:0] oea_reg;
  reg [7:0] outa_reg;
  reg [7:0] epcfg_reg;
  reg [7:0] pins_a_reg;
  reg [7:0] pins_b_reg;
  reg [7:0] pins_d_reg;
  reg [7:0] rdata_next;
  wire [1:0] mode;
  wire slave_mode;
  wire fifo_mode;
  wire word_wide;
  wire cs_used;
  wire cs_ok;
  wire wake1_lvl;
  wire wake1_rise;
  wire wake2_lvl;
  wire wake2_rise;
  wire wake2_on;
  wire rd_act;
  wire wr_act;
  wire oe_act;
  wire pkt_act;
  wire [1:0] sel;
  integer i;

  // mode field only changes at a clock edge, so pin muxing never sees a half update
  assign mode = ifmode_reg[1:0];
  assign slave_mode = (mode == `IPM_MODE_SLAVE);
  assign fifo_mode = (mode == `IPM_MODE_SLAVE) || (mode == `IPM_MODE_WAVE);
  assign word_wide = epcfg_reg[`IPM_EP_WIDE];
  assign cs_used = slave_mode && pacfg_reg[`IPM_PACFG_CS];
  assign cs_ok = !cs_used || !port_a_in[7];
  assign sel = port_a_in[5:4];
  assign wake2_on = wake_reg[`IPM_WAKE_EN2] && wake_reg[`IPM_WAKE_SEL2] && !oea_reg[3];

  // register file
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ifmode_reg <= `IPM_RST_BYTE;
      polar_reg <= `IPM_RST_BYTE;
      pacfg_reg <= `IPM_RST_BYTE;
      wake_reg <= `IPM_RST_BYTE;
      oea_reg <= `IPM_RST_BYTE;
      outa_reg <= `IPM_RST_BYTE;
      epcfg_reg <= `IPM_RST_BYTE;
      reg_rdata <= `IPM_RST_BYTE;
    end else begin
      if (reg_wr) begin
        if (reg_addr == `IPM_REG_IFMODE) begin
          ifmode_reg <= reg_wdata;
        end else if (reg_addr == `IPM_REG_POLAR) begin
          polar_reg <= reg_wdata;
        end else if (reg_addr == `IPM_REG_PACFG) begin
          pacfg_reg <= reg_wdata;
        end else if (reg_addr == `IPM_REG_WAKE) begin
          wake_reg <= reg_wdata;
        end else if (reg_addr == `IPM_REG_OEA) begin
          oea_reg <= reg_wdata;
        end else if (reg_addr == `IPM_REG_OUTA) begin
          outa_reg <= reg_wdata;
        end else if (reg_addr == `IPM_REG_EPCFG) begin
          epcfg_reg <= reg_wdata;
        end
      end
      reg_rdata <= reg_rd ? rdata_next : `IPM_RST_BYTE;
    end
  end

  always @* begin
    if (reg_addr == `IPM_REG_IFMODE) begin
      rdata_next = ifmode_reg;
    end else if (reg_addr == `IPM_REG_POLAR) begin
      rdata_next = polar_reg;
    end else if (reg_addr == `IPM_REG_PACFG) begin
      rdata_next = pacfg_reg;
    end else if (reg_addr == `IPM_REG_WAKE) begin
      rdata_next = wake_reg;
    end else if (reg_addr == `IPM_REG_OEA) begin
      rdata_next = oea_reg;
    end else if (reg_addr == `IPM_REG_OUTA) begin
      rdata_next = outa_reg;
    end else if (reg_addr == `IPM_REG_STATUS) begin
      rdata_next = {core_suspended, suspend_allowed, wake2_lvl, wake1_lvl,
                    fifo_output_enable, fifo_write_strobe, fifo_read_strobe, slave_mode};
    end else begin
      rdata_next = epcfg_reg;
    end
  end

  // polarity-corrected slave inputs and wake sources
  ipm_pol_in u_rd (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(ready_input_0),
    .active_high(polar_reg[`IPM_POL_RD]), .level(rd_act), .rise());
  ipm_pol_in u_wr (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(ready_input_1),
    .active_high(polar_reg[`IPM_POL_WR]), .level(wr_act), .rise());
  ipm_pol_in u_oe (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_a_in[2]),
    .active_high(polar_reg[`IPM_POL_OE]), .level(oe_act), .rise());
  ipm_pol_in u_pkt (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_a_in[6]),
    .active_high(polar_reg[`IPM_POL_PKT]), .level(pkt_act), .rise());
  ipm_pol_in u_wk1 (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(wake_pin),
    .active_high(wake_reg[`IPM_WAKE_POL]), .level(wake1_lvl), .rise(wake1_rise));
  ipm_pol_in u_wk2 (.ref_clk(ref_clk), .sys_rst(sys_rst), .pin_in(port_a_in[3]),
    .active_high(wake_reg[`IPM_WAKE_POL]), .level(wake2_lvl), .rise(wake2_rise));

  // external interrupts on port a bits 0 and 1
  ipm_ext_irq u_irq0 (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .enable(pacfg_reg[`IPM_PACFG_IRQ0]), .pin_n(port_a_in[0]),
    .edge_mode(wake_reg[`IPM_IT0]), .ack(irq0_ack), .irq(ext_irq0));
  ipm_ext_irq u_irq1 (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .enable(pacfg_reg[`IPM_PACFG_IRQ1]), .pin_n(port_a_in[1]),
    .edge_mode(wake_reg[`IPM_IT1]), .ack(irq1_ack), .irq(ext_irq1));

  // core-facing fifo strobes, gated by mode and chip select
  always @* begin
    fifo_select = slave_mode ? sel : 2'b00;
    fifo_read_strobe = slave_mode && cs_ok && rd_act;
    fifo_write_strobe = slave_mode && cs_ok && wr_act;
    fifo_output_enable = slave_mode && cs_ok && oe_act;
    packet_commit_input = slave_mode && cs_ok && pkt_act;
    ready_to_engine = (mode == `IPM_MODE_WAVE) ? {ready_input_1, ready_input_0} : 2'b00;
    shared_data_in = {pins_d_reg, pins_b_reg};
    port_a_pins = pins_a_reg;
  end

  // wake and suspend gating, a held wake level refuses suspend
  always @* begin
    osc_restart = core_suspended && (wake1_rise || (wake2_on && wake2_rise));
    wake_irq = osc_restart;
    suspend_allowed = suspend_request && !wake1_lvl && !(wake2_on && wake2_lvl);
  end

  // registered pin drivers; flops keep outputs free of decode glitches
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      port_a_out <= `IPM_RST_BYTE;
      port_a_oe_n <= 8'hff;
      port_b_out <= `IPM_RST_BYTE;
      port_b_oe_n <= 8'hff;
      port_d_out <= `IPM_RST_BYTE;
      port_d_oe_n <= 8'hff;
      ctl_pin_out <= 3'b111;
      pins_a_reg <= `IPM_RST_BYTE;
      pins_b_reg <= `IPM_RST_BYTE;
      pins_d_reg <= `IPM_RST_BYTE;
    end else begin
      pins_a_reg <= port_a_in;
      pins_b_reg <= port_b_in;
      pins_d_reg <= port_d_in;
      for (i = 0; i < 8; i = i + 1) begin
        port_a_out[i] <= outa_reg[i];
        port_a_oe_n[i] <= ~oea_reg[i];
      end
      // alternate inputs release the port driver
      if (pacfg_reg[`IPM_PACFG_IRQ0]) port_a_oe_n[0] <= 1'b1;
      if (pacfg_reg[`IPM_PACFG_IRQ1]) port_a_oe_n[1] <= 1'b1;
      if (wake2_on) port_a_oe_n[3] <= 1'b1;
      if (slave_mode) begin
        port_a_oe_n[2] <= 1'b1;
        port_a_oe_n[5:4] <= 2'b11;
        port_a_oe_n[6] <= 1'b1;
        if (pacfg_reg[`IPM_PACFG_CS]) begin
          port_a_oe_n[7] <= 1'b1;
        end else begin
          port_a_out[7] <= fifo_flag_d[sel];
          port_a_oe_n[7] <= 1'b0;
        end
        ctl_pin_out <= {fifo_empty_flag[sel], fifo_full_flag[sel], fifo_level_flag[sel]};
      end else if (mode == `IPM_MODE_WAVE) begin
        ctl_pin_out <= waveform_ctrl_out;
      end else begin
        ctl_pin_out <= 3'b111;
      end
      if (fifo_mode) begin
        // slave mode drives data only while the outside enables it
        port_b_out <= slave_mode ? fifo_read_data[7:0] : waveform_data_out[7:0];
        port_b_oe_n <= slave_mode ? {8{~fifo_output_enable}} : {8{~waveform_data_drive}};
      end else begin
        port_b_out <= port_b_reg_out;
        port_b_oe_n <= ~port_b_reg_oe;
      end
      if (fifo_mode && word_wide) begin
        port_d_out <= slave_mode ? fifo_read_data[15:8] : waveform_data_out[15:8];
        port_d_oe_n <= slave_mode ? {8{~fifo_output_enable}} : {8{~waveform_data_drive}};
      end else begin
        port_d_out <= port_d_reg_out;
        port_d_oe_n <= ~port_d_reg_oe;
      end
    end
  end
endmodule // ipm_pin_mux

//--- shared/ipm_consts.vh
`ifndef IPM_CONSTS_VH
`define IPM_CONSTS_VH
// interface mode field
`define IPM_MODE_PORTS 2'b00
`define IPM_MODE_RSVD 2'b01
`define IPM_MODE_WAVE 2'b10
`define IPM_MODE_SLAVE 2'b11
// register indices
`define IPM_REG_IFMODE 3'h0
`define IPM_REG_POLAR 3'h1
`define IPM_REG_PACFG 3'h2
`define IPM_REG_WAKE 3'h3
`define IPM_REG_OEA 3'h4
`define IPM_REG_OUTA 3'h5
`define IPM_REG_STATUS 3'h6
`define IPM_REG_EPCFG 3'h7
// field positions
`define IPM_POL_RD 3
`define IPM_POL_WR 2
`define IPM_POL_OE 4
`define IPM_POL_PKT 5
`define IPM_PACFG_IRQ0 0
`define IPM_PACFG_IRQ1 1
`define IPM_PACFG_CS 7
`define IPM_WAKE_EN2 1
`define IPM_WAKE_POL 4
`define IPM_WAKE_SEL2 7
`define IPM_IT0 2
`define IPM_IT1 3
`define IPM_EP_WIDE 0
// reset values
`define IPM_RST_BYTE 8'h00
`endif

//--- rtl/ipm_pol_in.v
`timescale 1ns/100ps
// polarity-corrected input with one-cycle rising-edge pulse
module ipm_pol_in (
  input wire ref_clk,
  input wire sys_rst,
  input wire pin_in,
  input wire active_high,
  output wire level,
  output wire rise
);
  reg last_reg;
  assign level = active_high ? pin_in : ~pin_in;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level;
    end
  end
  assign rise = level & ~last_reg;
endmodule // ipm_pol_in

//--- rtl/ipm_ext_irq.v
`timescale 1ns/100ps
// active-low interrupt request, edge or level triggered
module ipm_ext_irq (
  input wire ref_clk,
  input wire sys_rst,
  input wire enable,
  input wire pin_n,
  input wire edge_mode,
  input wire ack,
  output reg irq
);
  reg last_reg;
  reg flag_reg;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      last_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else begin
      last_reg <= pin_n;
      // set wins over acknowledge
      if (enable && last_reg && !pin_n) begin
        flag_reg <= 1'b1;
      end else if (ack || !enable) begin
        flag_reg <= 1'b0;
      end
    end
  end
  always @* begin
    irq = enable & (edge_mode ? flag_reg : ~pin_n);
  end
endmodule // ipm_ext_irq

//--- verif/ipm_mux_checker.sv
`timescale 1ns/100ps
`include "ipm_consts.vh"
module ipm_mux_checker (
  input wire ref_clk,
  input wire sys_rst,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire [7:0] port_a_in,
  input wire [7:0] port_b_oe_n,
  input wire ready_input_0,
  input wire ready_input_1,
  input wire [2:0] ctl_pin_out,
  input wire [1:0] ready_to_engine,
  input wire [3:0] fifo_level_flag,
  input wire [3:0] fifo_full_flag,
  input wire [3:0] fifo_empty_flag,
  input wire fifo_read_strobe,
  input wire fifo_output_enable,
  input wire wake_pin,
  input wire suspend_allowed
);
  reg [7:0] mode_q, pol_q, cfg_q, wk_q;
  // shadow of the written registers, sampled at the same edge as the design
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_q <= 8'h00;
      pol_q <= 8'h00;
      cfg_q <= 8'h00;
      wk_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == `IPM_REG_IFMODE) mode_q <= reg_wdata;
      if (reg_addr == `IPM_REG_POLAR) pol_q <= reg_wdata;
      if (reg_addr == `IPM_REG_PACFG) cfg_q <= reg_wdata;
      if (reg_addr == `IPM_REG_WAKE) wk_q <= reg_wdata;
    end
  end
  wire slv = mode_q[1:0] == `IPM_MODE_SLAVE;
  wire cs_ok = !cfg_q[`IPM_PACFG_CS] || !port_a_in[7];
  wire wk_on = wake_pin == wk_q[`IPM_WAKE_POL];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_read_strobe: assert property (fifo_read_strobe == (slv && cs_ok && ready_input_0 == pol_q[3]))
    else $error("read strobe wrong");
  a_oe_strobe: assert property (fifo_output_enable == (slv && cs_ok && port_a_in[2] == pol_q[4]))
    else $error("output enable wrong");
  a_ready_wave: assert property (mode_q[1:0] == `IPM_MODE_WAVE |-> ready_to_engine == {ready_input_1, ready_input_0})
    else $error("ready pins wrong");
  a_flags_slave: assert property ($past(slv) |-> ctl_pin_out == $past({fifo_empty_flag[port_a_in[5:4]],
    fifo_full_flag[port_a_in[5:4]], fifo_level_flag[port_a_in[5:4]]})) else $error("status flags wrong");
  a_ctl_port: assert property (!$past(mode_q[1]) |-> ctl_pin_out == 3'h7)
    else $error("control pins not idle");
  a_wake_block: assert property (wk_on [*3] |-> !suspend_allowed)
    else $error("suspend not blocked");
  a_reset_pins: assert property (disable iff (1'b0) sys_rst |=> ctl_pin_out == 3'h7 && port_b_oe_n == 8'hff)
    else $error("reset pins wrong");
  c_slave_read: cover property (slv && fifo_read_strobe);
  c_wave_ready: cover property (mode_q[1:0] == `IPM_MODE_WAVE && ready_to_engine != 2'h0);
  c_wake_held: cover property (wk_on [*3]);
endmodule // ipm_mux_checker

//--- verif/ipm_fifo_master.sv
`timescale 1ns/100ps
// external fifo master: strobes framed by chip select, polarity per request
module ipm_fifo_master (
  input wire ref_clk,
  input wire [2:0] go,
  input wire [2:0] pol,
  input wire [1:0] sel,
  input wire cs_off,
  output reg ready_input_0 = 1'b0,
  output reg ready_input_1 = 1'b0,
  output reg oe_pin = 1'b0,
  output reg cs_n = 1'b1,
  output reg [1:0] adr = 2'h0
);
  // idle strobes rest at their inactive level, never at a stale active one
  always @(posedge ref_clk) begin
    // cs_off lets the bench strobe with the chip deselected
    cs_n <= (~|go) | cs_off;
    adr <= sel;
    ready_input_0 <= go[1] ~^ pol[1];
    ready_input_1 <= go[0] ~^ pol[0];
    oe_pin <= go[2] ~^ pol[2];
  end
endmodule // ipm_fifo_master

//--- verif/tb_ipm_pin_mux.sv
`timescale 1ns/100ps
`include "ipm_consts.vh"
module tb_ipm_pin_mux;
  logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, waveform_data_drive = 1'b0;
  logic wake_pin = 1'b0, core_suspended = 1'b0, suspend_request = 1'b1, irq0_ack = 1'b0;
  logic irq1_ack = 1'b0, cs_off = 1'b0;
  logic [2:0] reg_addr = 3'h0, waveform_ctrl_out = 3'h5, go = 3'h0, pol = 3'h0;
  logic [7:0] reg_wdata = 8'h00, port_b_in = 8'h5a, port_d_in = 8'hc3, pa_lo = 8'hff;
  logic [7:0] port_b_reg_out = 8'h96, port_b_reg_oe = 8'h0f, port_d_reg_out = 8'h69;
  logic [7:0] port_d_reg_oe = 8'h3c;
  logic [3:0] fifo_level_flag = 4'h1, fifo_full_flag = 4'h2, fifo_empty_flag = 4'h4;
  logic [3:0] fifo_flag_d = 4'h0;
  logic [15:0] waveform_data_out = 16'h0000, fifo_read_data = 16'h0000;
  logic [1:0] sel = 2'h0;
  wire ready_input_0, ready_input_1, oe_pin, cs_n;
  wire [1:0] adr, ready_to_engine, fifo_select;
  wire [7:0] port_a_in = {cs_n, pa_lo[6], adr, pa_lo[3], oe_pin, pa_lo[1:0]};
  wire [7:0] reg_rdata, port_a_out, port_a_oe_n, port_b_out, port_b_oe_n;
  wire [7:0] port_d_out, port_d_oe_n, port_a_pins;
  wire [2:0] ctl_pin_out;
  wire [15:0] shared_data_in;
  wire fifo_read_strobe, fifo_write_strobe, fifo_output_enable, packet_commit_input;
  wire ext_irq0, ext_irq1, osc_restart, wake_irq, suspend_allowed;
  int bad_count = 0, compares = 0, n;
  always #5 ref_clk = ~ref_clk;
  ipm_pin_mux u_ipm_pin_mux (.*);
  ipm_fifo_master u_ipm_fifo_master (.ref_clk, .go, .pol, .sel, .cs_off, .ready_input_0,
    .ready_input_1, .oe_pin, .cs_n, .adr);
  task chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    step(2);
    chk(ctl_pin_out, 3'h7);
    chk({port_d_oe_n, port_b_oe_n}, {~port_d_reg_oe, ~port_b_reg_oe});
    chk({port_a_pins, port_d_out, port_b_out}, {port_a_in, port_d_reg_out, port_b_reg_out});
    rd(`IPM_REG_IFMODE, 8'h00);
    wr(`IPM_REG_OEA, 8'hff);
    wr(`IPM_REG_OUTA, 8'ha5);
    step(1);
    chk({port_a_oe_n, port_a_out}, 16'h00a5);
    wr(`IPM_REG_PACFG, 8'h83);
    wr(`IPM_REG_WAKE, 8'h14);
    wr(`IPM_REG_IFMODE, {6'h00, `IPM_MODE_SLAVE});
    rd(`IPM_REG_IFMODE, {6'h00, `IPM_MODE_SLAVE});
    chk({port_a_oe_n, port_a_out}, 16'hf7a5);
    for (int p = 0; p < 2; p++) begin
      wr(`IPM_REG_POLAR, p ? 8'h1c : 8'h00);
      pol <= {3{p[0]}};
      for (int k = 0; k < 3; k++) begin
        @(posedge ref_clk);
        go <= 3'h1 << k;
        step(2);
        chk({fifo_output_enable, fifo_read_strobe, fifo_write_strobe}, 3'h1 << k);
        @(posedge ref_clk);
        go <= 3'h0;
        step(2);
        chk({fifo_output_enable, fifo_read_strobe, fifo_write_strobe}, 3'h0);
      end
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      sel <= s[1:0];
      go <= 3'h4;
      step(3);
      chk({fifo_select, ctl_pin_out}, {s[1:0], fifo_empty_flag[s], fifo_full_flag[s],
        fifo_level_flag[s]});
    end
    pa_lo[6] <= 1'b0;
    step(1);
    chk(packet_commit_input, 1'b1);
    cs_off <= 1'b1;
    go <= 3'h7;
    step(2);
    chk({packet_commit_input, fifo_output_enable, fifo_read_strobe, fifo_write_strobe}, 4'h0);
    pa_lo[6] <= 1'b1;
    cs_off <= 1'b0;
    wr(`IPM_REG_IFMODE, {6'h00, `IPM_MODE_WAVE});
    go <= 3'h1;
    step(3);
    chk({ready_to_engine, ctl_pin_out}, {2'h2, waveform_ctrl_out});
    chk(shared_data_in, {port_d_in, port_b_in});
    chk({port_d_oe_n, port_b_oe_n, fifo_read_strobe}, {~port_d_reg_oe, 8'hff, 1'b0});
    waveform_data_drive <= 1'b1;
    waveform_data_out <= 16'hbeef;
    wr(`IPM_REG_EPCFG, 8'h01);
    step(1);
    chk({port_d_out, port_b_out}, 16'hbeef);
    chk({port_d_oe_n, port_b_oe_n}, 16'h0000);
    @(posedge ref_clk);
    core_suspended <= 1'b1;
    wake_pin <= 1'b1;
    n = 0;
    // the wake pulse stands one cycle only, so look mid-cycle
    repeat (6) begin
      @(negedge ref_clk);
      if ({osc_restart, wake_irq} === 2'b11) n++;
    end
    chk(n[3:0], 4'h1);
    chk(suspend_allowed, 1'b0);
    @(posedge ref_clk);
    wake_pin <= 1'b0;
    core_suspended <= 1'b0;
    pa_lo[1:0] <= 2'h0;
    step(2);
    pa_lo[0] <= 1'b1;
    step(3);
    chk({suspend_allowed, ext_irq1, ext_irq0}, 3'h7);
    pa_lo[1] <= 1'b1;
    irq0_ack <= 1'b1;
    irq1_ack <= 1'b1;
    @(posedge ref_clk);
    irq0_ack <= 1'b0;
    irq1_ack <= 1'b0;
    step(3);
    chk({ext_irq1, ext_irq0}, 2'h0);
    pa_lo[3] <= 1'b0;
    wr(`IPM_REG_OEA, 8'hf7);
    wr(`IPM_REG_WAKE, 8'h96);
    core_suspended <= 1'b1;
    pa_lo[3] <= 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge ref_clk);
      if ({osc_restart, wake_irq} === 2'b11) n++;
    end
    chk({suspend_allowed, port_a_oe_n[3], n[3:0]}, {2'b01, 4'h1});
    test_done;
  end
endmodule // tb_ipm_pin_mux
bind ipm_pin_mux ipm_mux_checker u_ipm_mux_checker (.*);
